// File: tm3_clksel.v
// clock source prescaler and selector for the timer 3 front end
// assumes clk is the fast clock; the slow clock pin and the counter pin are asynchronous
`include "tm3_map.vh"
`timescale 1ns/10ps
`default_nettype none

module tm3_clksel (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  input wire ce,
  // pins
  input wire low_freq_clk_pin,
  input wire count_pin,
  // selection
  input wire [2:0] clk_code,
  input wire prescaler_source_select,
  input wire low_speed,
  // result
  output reg src_tick,
  output reg src_legal
);

  reg [`TM3_PRE_W-1:0] pre_r;
  reg [`TM3_SLOW_DIV_W-1:0] slowdiv_r;
  reg [1:0] slow_sync_r;
  reg [1:0] pin_sync_r;
  reg slow_prev_r;
  reg pin_prev_r;
  wire slow_edge;
  wire pin_edge;
  wire slow8_tick;

  assign slow_edge = slow_sync_r[1] & ~slow_prev_r;
  assign pin_edge = pin_sync_r[1] & ~pin_prev_r;
  assign slow8_tick = slow_edge & (&slowdiv_r);

  // ============================================================
  // synchronisers, edge detect, dividers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r <= {`TM3_PRE_W{1'b0}};
      slowdiv_r <= {`TM3_SLOW_DIV_W{1'b0}};
      slow_sync_r <= 2'b00;
      pin_sync_r <= 2'b00;
      slow_prev_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else if (ce) begin
      pre_r <= pre_r + {{(`TM3_PRE_W-1){1'b0}}, 1'b1};
      slow_sync_r <= {slow_sync_r[0], low_freq_clk_pin};
      pin_sync_r <= {pin_sync_r[0], count_pin};
      slow_prev_r <= slow_sync_r[1];
      pin_prev_r <= pin_sync_r[1];
      if (slow_edge) begin
        slowdiv_r <= slowdiv_r + {{(`TM3_SLOW_DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ============================================================
  // source mux; at low speed the fast taps are masked, so codes 001, 010, 011 and 101 give no tick
  always @* begin
    src_tick = 1'b0;
    src_legal = 1'b1;
    case (clk_code)
      `TM3_CK_SLOW0: begin
        if (prescaler_source_select | low_speed) begin
          src_tick = slow8_tick; // [RULE2]
        end else begin
          src_tick = &pre_r[10:0]; // [RULE1]
        end
      end
      `TM3_CK_DIV7: src_tick = &pre_r[6:0]; // [RULE1]
      `TM3_CK_DIV5: src_tick = &pre_r[4:0]; // [RULE1]
      `TM3_CK_DIV3: src_tick = &pre_r[2:0]; // [RULE1]
      `TM3_CK_SLOW: src_tick = slow_edge; // [RULE1]
      `TM3_CK_DIV1: src_tick = pre_r[0]; // [RULE1]
      `TM3_CK_FAST: src_tick = 1'b1; // [RULE1]
      default: src_tick = pin_edge; // [RULE1]
    endcase
    if (low_speed) begin
      case (clk_code)
        `TM3_CK_SLOW0, `TM3_CK_SLOW, `TM3_CK_FAST, `TM3_CK_PIN: src_legal = 1'b1; // [RULE2]
        default: begin
          src_legal = 1'b0; // [RULE2]
          src_tick = 1'b0;
        end
      endcase
    end
  end

endmodule // tm3_clksel

`default_nettype wire

// File: tm3_map.vh
// constants for the timer 3 control front end: register word indexes, fields, codes, resets
// assumes a 32-bit avalon-mm bus with byte addresses; register index = address[4:2]
// ============================================================
// Function
// RULE1 - at full or halted-core speed with prescaler select 0, codes 000..110 pick fast/2^11, fast/2^7, fast/2^5, fast/2^3, slow, fast/2, fast and 111 the pin.
// RULE2 - with prescaler select 1 code 000 picks slow/2^3, and at low speed only 000 (slow/2^3), 100 (slow), 110 (fast) and the pin are usable.
// RULE3 - software picks the fast clock at low speed only when the counter serves as the warm-up counter.
// RULE4 - mode 000 is 8-bit timer, 001 divider output, 010 pwm, 011 16-bit cascade, and 1** is reserved.
// RULE5 - in cascade software holds this mode at 011 and the working mode comes from the partner mode field.
// RULE6 - in cascade the clock comes from this clock field while run and flip-flop level come from the partner bits.
// RULE7 - software leaves mode, clock and flip-flop bits alone while running and in the stopping write.
// RULE8 - new mode, clock and flip-flop values take effect in the write that moves run from 0 to 1.
// RULE9 - software does not rewrite the period register while running.
// RULE10 - the pulse-width register may change while running only in 8-bit or 16-bit pwm.
// RULE11 - the counter has one control register and two 8-bit timer registers, period and pulse width.
// RULE12 - flip-flop control 0 clears and 1 sets the output flip-flop when the counter starts.
// RULE13 - when the partner mode top bit is set the upper byte is clocked by this counter overflow.
// ============================================================
`ifndef TM3_MAP_VH
`define TM3_MAP_VH

// register word indexes
`define TM3_IDX_CONTROL 3'h0
`define TM3_IDX_PERIOD 3'h1
`define TM3_IDX_PULSE 3'h2
`define TM3_IDX_STATUS 3'h3
`define TM3_IDX_CONFIG 3'h4

// control register fields
`define TM3_FF_BIT 7
`define TM3_CK_HI 6
`define TM3_CK_LO 4
`define TM3_RUN_BIT 3
`define TM3_MODE_HI 2
`define TM3_MODE_LO 0

// reset values
`define TM3_RST_CONTROL 8'h00
`define TM3_RST_PERIOD 8'h00
`define TM3_RST_PULSE 8'h00

// operating modes
`define TM3_MODE_TIMER 3'h0
`define TM3_MODE_DIVOUT 3'h1
`define TM3_MODE_PWM8 3'h2
`define TM3_MODE_CASCADE 3'h3
`define TM3_PMODE_PWM16 3'h6

// clock codes
`define TM3_CK_SLOW0 3'h0
`define TM3_CK_DIV7 3'h1
`define TM3_CK_DIV5 3'h2
`define TM3_CK_DIV3 3'h3
`define TM3_CK_SLOW 3'h4
`define TM3_CK_DIV1 3'h5
`define TM3_CK_FAST 3'h6
`define TM3_CK_PIN 3'h7

// prescaler tap lengths: fast/2^n ticks when the low n bits are all ones
`define TM3_PRE_W 11
`define TM3_SLOW_DIV_W 3

`endif

// File: tm3_timer_ctrl.v
// timer 3 control and configuration front end with avalon-mm register slave
// assumes single clock clk = fast clock; partner counter signals come from logic on the same clock
`include "tm3_map.vh"
`timescale 1ns/10ps
`default_nettype none

module tm3_timer_ctrl (
  // clock, reset, enable
  input wire clk,
  input wire sys_rst,
  input wire ce,
  // avalon-mm slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // system state
  input wire [1:0] power_mode,
  // pins
  input wire low_freq_clk_pin,
  input wire count_pin,
  // partner counter
  input wire [2:0] partner_mode_select,
  input wire partner_run_control,
  input wire partner_flipflop_control,
  input wire partner_tick,
  input wire lower_overflow,
  // to counting datapath
  output reg count_tick_r,
  output reg upper_tick_r,
  output reg run_r,
  output reg [2:0] mode_r,
  output reg cascade_r,
  output reg output_ff_r,
  output reg [7:0] period_compare_r,
  output reg [7:0] pulse_width_r
);

  // power modes: bit1 set means the low-speed clock drives the system
  localparam [1:0] PM_LOW_SPEED_RUN = 2'h2;

  // ============================================================
  // register state
  reg [7:0] control_r;
  reg prescaler_source_select_r;
  reg [2:0] act_ck_r;
  reg [2:0] act_mode_r;
  reg partner_run_prev_r;

  wire low_speed;
  wire [2:0] wr_ck;
  wire [2:0] wr_mode;
  wire wr_run;
  wire wr_ff;
  wire own_run;
  wire act_cascade;
  wire eff_run;
  wire [2:0] eff_mode;
  wire pwm_active;
  wire src_tick;
  wire src_legal;
  wire [2:0] idx;
  wire bus_req;
  wire do_write;
  wire start_write;
  wire partner_start;

  assign low_speed = |(power_mode & PM_LOW_SPEED_RUN);
  assign idx = avs_address[4:2];
  assign bus_req = avs_read | avs_write;
  // a write lands only at the edge where waitrequest is seen low
  assign do_write = avs_write & ~avs_waitrequest & avs_byteenable[0] & ce;
  assign wr_ck = avs_writedata[`TM3_CK_HI:`TM3_CK_LO];
  assign wr_mode = avs_writedata[`TM3_MODE_HI:`TM3_MODE_LO];
  assign wr_run = avs_writedata[`TM3_RUN_BIT];
  assign wr_ff = avs_writedata[`TM3_FF_BIT];
  assign own_run = control_r[`TM3_RUN_BIT];
  assign start_write = do_write & (idx == `TM3_IDX_CONTROL) & wr_run & ~own_run;

  // ============================================================
  // effective operation
  assign act_cascade = (act_mode_r == `TM3_MODE_CASCADE); // [RULE5]
  assign eff_mode = act_cascade ? partner_mode_select : act_mode_r; // [RULE5]
  assign eff_run = act_cascade ? partner_run_control : own_run; // [RULE6]
  assign partner_start = act_cascade & partner_run_control & ~partner_run_prev_r;
  assign pwm_active = act_cascade ? (partner_mode_select == `TM3_PMODE_PWM16)
                                  : (act_mode_r == `TM3_MODE_PWM8);

  tm3_clksel u_clksel (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .low_freq_clk_pin(low_freq_clk_pin),
    .count_pin(count_pin),
    .clk_code(act_ck_r), // [RULE6]
    .prescaler_source_select(prescaler_source_select_r),
    .low_speed(low_speed),
    .src_tick(src_tick),
    .src_legal(src_legal)
  );

  // ============================================================
  // control register and active configuration
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_r <= `TM3_RST_CONTROL;
      act_ck_r <= `TM3_CK_SLOW0;
      act_mode_r <= `TM3_MODE_TIMER;
      prescaler_source_select_r <= 1'b0;
    end else if (do_write) begin
      if (idx == `TM3_IDX_CONTROL) begin
        control_r <= avs_writedata[7:0]; // [RULE11]
        if (start_write) begin
          // settings written while stopped only go live at the start write
          act_ck_r <= wr_ck; // [RULE8]
          act_mode_r <= wr_mode; // [RULE8]
        end
      end else if (idx == `TM3_IDX_CONFIG) begin
        prescaler_source_select_r <= avs_writedata[0];
      end
    end
  end

  // ============================================================
  // timer registers: rewrites while running are dropped, pulse width excepted in pwm
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      period_compare_r <= `TM3_RST_PERIOD;
      pulse_width_r <= `TM3_RST_PULSE;
    end else if (do_write) begin
      if ((idx == `TM3_IDX_PERIOD) && !eff_run) begin
        period_compare_r <= avs_writedata[7:0]; // [RULE9] [RULE11]
      end else if ((idx == `TM3_IDX_PULSE) && (!eff_run || pwm_active)) begin
        pulse_width_r <= avs_writedata[7:0]; // [RULE10] [RULE11]
      end
    end
  end

  // ============================================================
  // output flip-flop initial level and datapath outputs
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_ff_r <= 1'b0;
      partner_run_prev_r <= 1'b0;
      count_tick_r <= 1'b0;
      upper_tick_r <= 1'b0;
      run_r <= 1'b0;
      mode_r <= `TM3_MODE_TIMER;
      cascade_r <= 1'b0;
    end else if (ce) begin
      partner_run_prev_r <= partner_run_control;
      if (start_write && (wr_mode != `TM3_MODE_CASCADE)) begin
        output_ff_r <= wr_ff; // [RULE12] [RULE8]
      end else if (partner_start) begin
        output_ff_r <= partner_flipflop_control; // [RULE6] [RULE12]
      end
      run_r <= eff_run; // [RULE6]
      mode_r <= eff_mode; // [RULE4] [RULE5]
      cascade_r <= act_cascade;
      count_tick_r <= eff_run & src_tick;
      if (partner_mode_select[2]) begin
        upper_tick_r <= lower_overflow; // [RULE13]
      end else begin
        upper_tick_r <= partner_tick;
      end
    end
  end

  // ============================================================
  // avalon-mm handshake: one wait cycle, then waitrequest low for exactly one cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        if (!avs_read) begin
          avs_readdata <= 32'h00000000;
        end else if (idx == `TM3_IDX_CONTROL) begin
          avs_readdata <= {24'h000000, control_r};
        end else if (idx == `TM3_IDX_PERIOD) begin
          avs_readdata <= {24'h000000, period_compare_r};
        end else if (idx == `TM3_IDX_PULSE) begin
          avs_readdata <= {24'h000000, pulse_width_r};
        end else if (idx == `TM3_IDX_STATUS) begin
          // reserved mode codes are flagged so software can spot them
          avs_readdata <= {24'h000000, ~src_legal, eff_mode[2], output_ff_r,
                           act_cascade, eff_mode, eff_run}; // [RULE4]
        end else if (idx == `TM3_IDX_CONFIG) begin
          avs_readdata <= {31'h00000000, prescaler_source_select_r};
        end else begin
          avs_readdata <= 32'h00000000;
        end
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

endmodule // tm3_timer_ctrl

`default_nettype wire

// File: tm3_timer_ctrl_sva.sv
// concurrent checks on the timer 3 control front end ports
// assumes it is bound into tm3_timer_ctrl and shares its clock and reset
`include "tm3_map.vh"
`timescale 1ns/10ps
`default_nettype none

module tm3_timer_ctrl_sva (
  // clock, reset and bus handshake
  input wire clk,
  input wire sys_rst,
  input wire ce,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // partner counter
  input wire [2:0] partner_mode_select,
  input wire partner_run_control,
  input wire partner_tick,
  input wire lower_overflow,
  // datapath outputs
  input wire count_tick_r,
  input wire upper_tick_r,
  input wire run_r,
  input wire [2:0] mode_r,
  input wire cascade_r,
  input wire [7:0] period_compare_r,
  input wire [7:0] pulse_width_r
);
  // ==========
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low longer than one cycle");
  req_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest && ce
    |=> !avs_waitrequest) else $error("request not answered");
  casc_mode_a: assert property (cascade_r |-> mode_r == $past(partner_mode_select))
    else $error("cascade mode not from partner");
  casc_run_a: assert property (cascade_r |-> run_r == $past(partner_run_control))
    else $error("cascade run not from partner");
  upper_ovf_a: assert property ($past(partner_mode_select[2]) |->
    upper_tick_r == $past(lower_overflow)) else $error("upper byte not on overflow");
  upper_own_a: assert property (!$past(partner_mode_select[2]) |->
    upper_tick_r == $past(partner_tick)) else $error("upper byte tick wrong");
  tick_gated_a: assert property (count_tick_r |-> run_r || $past(run_r))
    else $error("tick while stopped");
  period_lock_a: assert property (run_r && $past(run_r) |-> $stable(period_compare_r))
    else $error("period changed while running");
  pulse_lock_a: assert property (run_r && $past(run_r) && mode_r != `TM3_MODE_PWM8 &&
    mode_r != `TM3_PMODE_PWM16 |-> $stable(pulse_width_r))
    else $error("pulse width changed while running");
  mode_hold_a: assert property (run_r && $past(run_r) && !cascade_r |-> $stable(mode_r))
    else $error("mode changed while running");
endmodule // tm3_timer_ctrl_sva

bind tm3_timer_ctrl tm3_timer_ctrl_sva chk_u (.clk, .sys_rst, .ce, .avs_read, .avs_write,
  .avs_waitrequest, .partner_mode_select, .partner_run_control, .partner_tick, .lower_overflow,
  .count_tick_r, .upper_tick_r, .run_r, .mode_r, .cascade_r, .period_compare_r, .pulse_width_r);

`default_nettype wire

// File: tm3_timer_ctrl_tb_top.sv
// self-checking bench for the timer 3 control front end
// assumes the design and its checker are compiled first
`timescale 1ns/10ps
`default_nettype none

module tm3_timer_ctrl_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic slow_pin = 1'b0;
  logic cnt_pin = 1'b0;
  logic ptick = 1'b0;
  logic lovf = 1'b0;
  logic prun = 1'b0;
  logic pff = 1'b0;
  logic [7:0] pc = 8'h00;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [1:0] pm = 2'h0;
  logic [2:0] pms = 3'h0;
  logic [31:0] rdata, rdat;
  logic wreq, ctick, utick, run, casc, off;
  logic [2:0] mode;
  logic [7:0] per, pw, epw;
  int num_errors = 0;
  int check_count = 0;

  tm3_timer_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h1),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .power_mode(pm), .low_freq_clk_pin(slow_pin),
    .count_pin(cnt_pin), .partner_mode_select(pms), .partner_run_control(prun),
    .partner_flipflop_control(pff), .partner_tick(ptick), .lower_overflow(lovf),
    .count_tick_r(ctick), .upper_tick_r(utick), .run_r(run), .mode_r(mode),
    .cascade_r(casc), .output_ff_r(off), .period_compare_r(per), .pulse_width_r(pw));

  // ==========
  // stimulus helpers
  initial forever #25 clk = ~clk;

  // slow clock pin period 8 cycles, count pin period 4
  always @(posedge clk) if (!sys_rst) begin
    pc <= pc + 8'h01;
    slow_pin <= pc[2];
    cnt_pin <= pc[1];
    ptick <= pc[0];
    lovf <= &pc[2:0];
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    adr <= a;
    wd <= {24'h0, d};
    rd <= ~w;
    wr <= w;
    @(posedge clk);
    while (wreq !== 1'b0 && k < 20) begin
      k++;
      @(posedge clk);
    end
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 20) begin
      num_errors++;
      $display("mismatch at %0t: bus timeout", $time);
      tally_and_finish;
    end else begin
      @(posedge clk);
    end
  endtask

  // source ticks seen in a 2048-cycle window
  function automatic int ticks(input logic [2:0] ck, input logic low, input logic psel);
    case (ck)
      3'h0: ticks = (psel || low) ? 32 : 1;
      3'h1: ticks = low ? 0 : 16;
      3'h2: ticks = low ? 0 : 64;
      3'h3: ticks = low ? 0 : 256;
      3'h4: ticks = 256;
      3'h5: ticks = low ? 0 : 1024;
      3'h6: ticks = 2048;
      default: ticks = 512;
    endcase
  endfunction

  // ==========
  // tests
  initial begin
    logic [2:0] ck;
    logic low;
    int c;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 3; a++) begin
      bus(1'b0, 5'(4 * a), 8'h00);
      chk(rdat, 32'h0);
    end
    bus(1'b1, 5'h04, 8'h5a);
    bus(1'b1, 5'h08, 8'h3c);
    bus(1'b0, 5'h04, 8'h00);
    chk(rdat, 32'h5a);
    chk({24'h0, pw}, 32'h3c);
    epw = 8'h3c;
    $display("test storage done");
    for (int i = 0; i < 17; i++) begin
      ck = i[2:0];
      low = i[3];
      pm <= {low, 1'b0}; // fast code at low speed stands for warm-up use only
      bus(1'b1, 5'h10, {7'h0, i < 16});
      bus(1'b1, 5'h00, {ck[0], ck, 4'h0});
      bus(1'b1, 5'h00, {ck[0], ck, 4'h8});
      bus(1'b0, 5'h0c, 8'h00);
      chk(rdat, {24'h0, low && (ck == 1 || ck == 2 || ck == 3 || ck == 5), 1'b0, ck[0],
        5'h01});
      c = 0;
      repeat (2048) begin
        @(posedge clk);
        if (ctick === 1'b1) c++;
      end
      chk(c, ticks(ck, low, i < 16));
      bus(1'b1, 5'h00, {ck[0], ck, 4'h0});
    end
    $display("test clocks done");
    pm <= 2'h0;
    pms <= 3'h6;
    pff <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 5'h00, {5'h0c, m[2:0]});
      bus(1'b1, 5'h00, {5'h0d, m[2:0]});
      prun <= 1'b1;
      bus(1'b1, 5'h04, 8'h11);
      bus(1'b1, 5'h08, 8'h20 + 8'(m));
      if (m > 1) epw = 8'h20 + 8'(m);
      chk({24'h0, per}, 32'h5a);
      chk({24'h0, pw}, {24'h0, epw});
      bus(1'b0, 5'h0c, 8'h00);
      chk(rdat & 32'hffffffbf, {26'h0, m == 3, m == 3, m == 3 ? 3'h6 : m[2:0],
        1'b1});
      chk({30'h0, run, casc}, {30'h0, 1'b1, m == 3});
      chk({31'h0, off}, {31'h0, m == 3});
      prun <= 1'b0;
      bus(1'b1, 5'h00, {5'h0c, m[2:0]});
    end
    $display("test modes done");
    bus(1'b1, 5'h00, 8'h62);
    repeat (2) @(posedge clk);
    chk({29'h0, mode}, 32'h6);
    bus(1'b1, 5'h00, 8'h6a);
    repeat (2) @(posedge clk);
    chk({29'h0, mode}, 32'h2);
    chk({30'h0, run, casc}, 32'h2);
    chk({31'h0, off}, 32'h0);
    bus(1'b1, 5'h00, 8'h62);
    $display("test restart done");
    for (int u = 0; u < 2; u++) begin
      pms <= u ? 3'h2 : 3'h6;
      repeat (2) @(posedge clk);
      c = 0;
      repeat (64) begin
        @(posedge clk);
        if (utick === 1'b1) c++;
      end
      chk(c, u ? 32 : 8);
    end
    $display("test upper clock done");
    tally_and_finish;
  end
endmodule // tm3_timer_ctrl_tb_top

`default_nettype wire
